// ---- common/rfs_pkg.sv ----
// Purpose: Shared constants and types for the serial-bus slave register bank
// Assumes: 8-bit registers at 5-bit addresses 0x00..0x1F
// Notes:   Stored reset values are the power-on contents of each register
package rfs_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [4:0] A_OUT_EN      = 5'h00;
	localparam logic [4:0] A_RESP_SEL    = 5'h01;
	localparam logic [4:0] A_BOOST       = 5'h02;
	localparam logic [4:0] A_TIMER_A     = 5'h03;
	localparam logic [4:0] A_TARGET_A    = 5'h06;
	localparam logic [4:0] A_RDMODE      = 5'h09;
	localparam logic [4:0] A_SPARE_FIRST = 5'h0A;
	localparam logic [4:0] A_SPARE_LAST  = 5'h17;
	localparam logic [4:0] A_SID1        = 5'h18;
	localparam logic [4:0] A_SID2        = 5'h19;
	localparam logic [4:0] A_STATUS      = 5'h1A;
	localparam logic [4:0] A_GROUP       = 5'h1B;
	localparam logic [4:0] A_PWR_TRIG    = 5'h1C;
	localparam logic [4:0] A_PROD_ID     = 5'h1D;
	localparam logic [4:0] A_MANUF_ID    = 5'h1E;
	localparam logic [4:0] A_SID0        = 5'h1F;

	// ==========================================================
	// Reset values
	localparam logic [2:0] RST_OUT_EN    = 3'h0;
	localparam logic [5:0] RST_RESP_SEL  = 6'h3F;
	localparam logic [7:0] RST_BOOST     = 8'hDB;
	localparam logic [7:0] RST_DAC_FIELD = 8'h00;
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [3:0] RST_SID       = 4'h7;
	localparam logic [7:0] RST_PWR_TRIG  = 8'h38;
	localparam logic [1:0] RST_STATUS    = 2'h0;

	// ==========================================================
	// Field positions and masks
	localparam int         RDM_BIT       = 0;
	localparam int         ST_WR_BIT     = 0;
	localparam int         ST_RD_BIT     = 1;
	localparam int         PT_MASK_LSB   = 3;
	localparam int         PT_PWR_LSB    = 6;
	localparam logic [7:0] BOOST_MASK    = 8'hDF;

	// ==========================================================
	// Command prefixes and frame counts
	localparam logic [2:0] CMD_WR        = 3'h2;
	localparam logic [2:0] CMD_RD        = 3'h3;
	localparam logic [3:0] CMD_EXT_WR    = 4'h0;
	localparam logic [3:0] CMD_EXT_RD    = 4'h2;
	localparam logic [4:0] CMD_LONG_WR   = 5'h06;
	localparam logic [4:0] CMD_LONG_RD   = 5'h07;
	localparam logic [3:0] BCAST_SID     = 4'h0;
	localparam logic [3:0] CMD_LAST      = 4'hC;
	localparam logic [3:0] BYTE_LAST     = 4'h8;

	// ==========================================================
	// Carriers between the link and the register side
	typedef enum logic [1:0] {K_WRITE, K_WLONG, K_RLONG} rfs_kind_t;

	typedef struct packed {
		rfs_kind_t  kind;
		logic [3:0] sa;
		logic [7:0] addr;
		logic [7:0] data;
	} rfs_xfer_t;

	typedef struct packed {
		logic [3:0] sa;
		logic [7:0] addr;
	} rfs_rdreq_t;

	typedef struct packed {
		logic       ok;
		logic [7:0] data;
	} rfs_rdata_t;

	typedef struct packed {
		logic [7:0] timer;
		logic [7:0] target;
	} rfs_dac_t;

endpackage

// ---- verilog/rfs_slave_regs.sv ----
// Purpose: Two-wire serial control slave with its 32-location register space
// Assumes: i_mclk at least four times the link clock; link clock idles low
// Notes:   Link frames are parsed on the link clock; registers live on i_mclk

// Overview of operation
// - Executes five supported read and write commands
// - Addresses 0x00 through 0x1F readable; all but 0x1D and 0x1E writable
// - Select bit set launches read data earlier
// - Long extended write: no update, flag set
// - Long extended read: line idle, flag set
// - Reads of 0x03-0x08 return active contents
// - Output registers reachable only under selected ID
// - 0x01 and 0x02 reachable under any own ID
// - Slave ID registers reachable own ID, broadcast writes
// - 0x1C holds power state and trigger
// - 0x1B holds group broadcast ID
// - 0x1A status holds unsupported-command flags
// - Product identifier read-only, low bit strapped
// - Ten-bit manufacturer identifier fixed in hardware
// - 0x09 holds the read capture edge select
// - 0x0A-0x17 spare storage, no effect
// - Every register eight bits wide
// - Response select restricts output writes by ID
// - 0x00 bits enable outputs immediately, default off
module rfs_slave_regs
	import rfs_pkg::*;
#(
	parameter logic [6:0] PRODUCT_ID_HI = 7'h15,  // Arbitrary value
	parameter logic [9:0] MANUF_ID      = 10'h2A5 // Arbitrary value
) (
	input  wire logic            i_mclk,
	input  wire logic            i_reset_n,
	input  wire logic            i_sclk,
	input  wire logic            i_sdata,
	input  wire logic            i_otp_pid_lsb,
	output logic                 o_sdata,
	output logic                 o_sdata_oe,
	output logic [2:0]           o_output_enable,
	output logic [7:0]           o_booster,
	output rfs_dac_t [2:0]       o_dac,
	output logic [1:0]           o_power_state
);

	typedef enum logic [2:0] {S_CMD, S_ADDR, S_WDATA, S_RPARK, S_RDATA, S_REND, S_IDLE} rfs_st_t;

	// ==========================================================
	// Register side storage
	logic [2:0]  out_en_r;
	logic [5:0]  resp_sel_r;
	logic [7:0]  boost_r;
	logic        rdm_r;
	logic [7:0]  spare_r [A_SPARE_FIRST:A_SPARE_LAST];
	logic [3:0]  sid_r [0:2];
	logic [1:0]  sid_sp_r [0:2];
	logic [7:0]  group_r;
	logic [7:0]  pt_r;
	logic [1:0]  status_r;
	rfs_dac_t    shadow_r [0:2];
	rfs_dac_t    active_r [0:2];
	rfs_rdata_t  rdata_r;

	// Crossing and frame-start logic on i_mclk
	logic        sclk_s1, sclk_s2, sd_s1, sd_s2, sd_s3, armed_r;
	logic        link_rst_r, frame_clr_r;
	logic        wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;

	// Link side
	rfs_st_t     st_r, st_nxt;
	logic [3:0]  cnt_r, cnt_nxt, sa_r, sa_nxt, bcnt_r, bcnt_nxt;
	logic [12:0] sh_r, sh_nxt, sh_in;
	logic [7:0]  addr_r, addr_nxt, rsh_r, rsh_nxt, cmd;
	logic        rdx_r, rdx_nxt, drv_r, drv_nxt, drv_oe_r, drv_oe_nxt, load;
	logic        wr_fire, rd_fire, wr_tgl_r, rd_tgl_r, std_r, std_oe_r, rdm_s1, rdm_s2;
	rfs_xfer_t   xfer_r, xfer_nxt;
	rfs_rdreq_t  rdreq_r, rdreq_nxt;

	// ==========================================================
	// Access decoding
	function automatic logic own(input logic [3:0] sa);
		own = (sa == sid_r[0]) || (sa == sid_r[1]) || (sa == sid_r[2]);
	endfunction

	function automatic logic sel_hit(input logic [1:0] sel, input logic [3:0] sa);
		sel_hit = (sel == 2'h3) ? own(sa) : (sa == sid_r[sel]);
	endfunction

	function automatic logic acc_ok(input logic [7:0] a, input logic [3:0] sa,
			input logic wr);
		logic bc;
		bc = wr && ((sa == BCAST_SID) || (sa == group_r[3:0]));
		acc_ok = 1'b0;
		if (a[7:5] == 3'h0) begin
			case (a[4:0])
				A_TIMER_A, A_TARGET_A:                     acc_ok = sel_hit(resp_sel_r[1:0], sa);
				A_TIMER_A + 5'h01, A_TARGET_A + 5'h01:     acc_ok = sel_hit(resp_sel_r[3:2], sa);
				A_TIMER_A + 5'h02, A_TARGET_A + 5'h02:     acc_ok = sel_hit(resp_sel_r[5:4], sa);
				A_SID0: acc_ok = (sa == sid_r[0]) || (wr && sa == BCAST_SID);
				A_SID1: acc_ok = (sa == sid_r[1]) || (wr && sa == BCAST_SID);
				A_SID2: acc_ok = (sa == sid_r[2]) || (wr && sa == BCAST_SID);
				A_PROD_ID, A_MANUF_ID: acc_ok = !wr && own(sa);
				default: acc_ok = own(sa) || bc;
			endcase
		end
	endfunction

	function automatic logic [7:0] rd_val(input logic [4:0] a);
		case (a)
			A_OUT_EN:          rd_val = {5'h00, out_en_r};
			A_RESP_SEL:        rd_val = {2'h0, resp_sel_r};
			A_BOOST:           rd_val = boost_r & BOOST_MASK;
			A_TIMER_A:         rd_val = active_r[0].timer;
			A_TIMER_A + 5'h01: rd_val = active_r[1].timer;
			A_TIMER_A + 5'h02: rd_val = active_r[2].timer;
			A_TARGET_A:         rd_val = active_r[0].target;
			A_TARGET_A + 5'h01: rd_val = active_r[1].target;
			A_TARGET_A + 5'h02: rd_val = active_r[2].target;
			A_RDMODE:          rd_val = {7'h00, rdm_r};
			A_SID0:            rd_val = {sid_sp_r[0], MANUF_ID[9:8], sid_r[0]};
			A_SID1:            rd_val = {sid_sp_r[1], MANUF_ID[9:8], sid_r[1]};
			A_SID2:            rd_val = {sid_sp_r[2], MANUF_ID[9:8], sid_r[2]};
			A_STATUS:          rd_val = {6'h00, status_r};
			A_GROUP:           rd_val = group_r;
			A_PWR_TRIG:        rd_val = pt_r;
			A_PROD_ID:         rd_val = {PRODUCT_ID_HI, i_otp_pid_lsb};
			A_MANUF_ID:        rd_val = MANUF_ID[7:0];
			default:           rd_val = spare_r[a];
		endcase
	endfunction

	// ==========================================================
	// Frame start detection and link resets
	always_ff @(posedge i_mclk) begin
		sclk_s1 <= i_sclk;
		sclk_s2 <= sclk_s1;
		sd_s1   <= i_sdata;
		sd_s2   <= sd_s1;
		sd_s3   <= sd_s2;
		if (!i_reset_n) begin
			armed_r     <= 1'b0;
			link_rst_r  <= 1'b1;
			frame_clr_r <= 1'b1;
		end else begin
			armed_r     <= !sclk_s2 && (armed_r || (sd_s2 && !sd_s3));
			link_rst_r  <= 1'b0;
			frame_clr_r <= armed_r && !sclk_s2 && sd_s3 && !sd_s2;
		end
	end

	// Event toggles from the link
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			{wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3} <= 6'h00;
		end else begin
			{wr_s1, wr_s2, wr_s3} <= {wr_tgl_r, wr_s1, wr_s2};
			{rd_s1, rd_s2, rd_s3} <= {rd_tgl_r, rd_s1, rd_s2};
		end
	end

	logic       wr_ev, we, lw_ev, lr_ev;
	logic [2:0] fire, mask;
	assign wr_ev = wr_s2 ^ wr_s3;
	assign we    = wr_ev && xfer_r.kind == K_WRITE && acc_ok(xfer_r.addr, xfer_r.sa, 1'b1);
	assign lw_ev = wr_ev && xfer_r.kind == K_WLONG && acc_ok(8'h00, xfer_r.sa, 1'b1);
	assign lr_ev = wr_ev && xfer_r.kind == K_RLONG && acc_ok(8'h00, xfer_r.sa, 1'b1);
	assign mask  = pt_r[PT_MASK_LSB +: 3];
	assign fire  = (we && xfer_r.addr[4:0] == A_PWR_TRIG) ?
		(xfer_r.data[2:0] & ~xfer_r.data[PT_MASK_LSB +: 3]) : 3'h0;

	// ==========================================================
	// Configuration registers
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			out_en_r   <= RST_OUT_EN;
			resp_sel_r <= RST_RESP_SEL;
			boost_r    <= RST_BOOST;
			rdm_r      <= 1'b0;
			group_r    <= RST_BYTE;
			pt_r       <= RST_PWR_TRIG;
			for (int i = 0; i < 3; i++) begin
				sid_r[i]    <= RST_SID;
				sid_sp_r[i] <= 2'h0;
			end
			for (int j = A_SPARE_FIRST; j <= A_SPARE_LAST; j++) begin
				spare_r[j] <= RST_BYTE;
			end
		end else if (we) begin
			case (xfer_r.addr[4:0])
				A_OUT_EN:   out_en_r   <= xfer_r.data[2:0];
				A_RESP_SEL: resp_sel_r <= xfer_r.data[5:0];
				A_BOOST:    boost_r    <= xfer_r.data;
				A_RDMODE:   rdm_r      <= xfer_r.data[RDM_BIT];
				A_GROUP:    group_r    <= xfer_r.data;
				A_PWR_TRIG: pt_r       <= {xfer_r.data[7:3], 3'h0};
				A_SID0:     {sid_sp_r[0], sid_r[0]} <= {xfer_r.data[7:6], xfer_r.data[3:0]};
				A_SID1:     {sid_sp_r[1], sid_r[1]} <= {xfer_r.data[7:6], xfer_r.data[3:0]};
				A_SID2:     {sid_sp_r[2], sid_r[2]} <= {xfer_r.data[7:6], xfer_r.data[3:0]};
				A_TIMER_A, A_TIMER_A + 5'h01, A_TIMER_A + 5'h02,
				A_TARGET_A, A_TARGET_A + 5'h01, A_TARGET_A + 5'h02,
				A_STATUS, A_PROD_ID, A_MANUF_ID: ;
				default:    spare_r[xfer_r.addr[4:0]] <= xfer_r.data;
			endcase
		end
	end

	// ==========================================================
	// Output shadow and active copies
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			for (int i = 0; i < 3; i++) begin
				shadow_r[i] <= {RST_DAC_FIELD, RST_DAC_FIELD};
				active_r[i] <= {RST_DAC_FIELD, RST_DAC_FIELD};
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				logic [1:0] sel;
				logic       imm;
				sel = resp_sel_r[2*i +: 2];
				imm = (sel == 2'h3) ? &mask : mask[sel];
				if (we && xfer_r.addr[4:0] == A_TIMER_A + 5'(i)) begin
					shadow_r[i].timer <= xfer_r.data;
					if (imm) begin
						active_r[i].timer <= xfer_r.data;
					end
				end else if (we && xfer_r.addr[4:0] == A_TARGET_A + 5'(i)) begin
					shadow_r[i].target <= xfer_r.data;
					if (imm) begin
						active_r[i].target <= xfer_r.data;
					end
				end else if ((sel == 2'h3) ? |fire : fire[sel]) begin
					active_r[i] <= shadow_r[i];
				end
			end
		end
	end

	// ==========================================================
	// Status flags and read data
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			status_r <= RST_STATUS;
		end else begin
			logic [1:0] clr;
			clr = (we && xfer_r.addr[4:0] == A_STATUS) ? xfer_r.data[1:0] : 2'h0;
			status_r[ST_WR_BIT] <= lw_ev || (status_r[ST_WR_BIT] && !clr[ST_WR_BIT]);
			status_r[ST_RD_BIT] <= lr_ev || (status_r[ST_RD_BIT] && !clr[ST_RD_BIT]);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rdata_r <= '0;
		end else if (rd_s2 ^ rd_s3) begin
			rdata_r.ok   <= acc_ok(rdreq_r.addr, rdreq_r.sa, 1'b0);
			rdata_r.data <= rd_val(rdreq_r.addr[4:0]);
		end
	end

	assign o_output_enable = out_en_r;
	assign o_booster       = boost_r & BOOST_MASK;
	assign o_power_state   = pt_r[PT_PWR_LSB +: 2];
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			o_dac[i] = active_r[i];
		end
	end

	// ==========================================================
	// Link frame parser, data sampled on falling edges
	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r + 4'h1;
		sh_in      = {sh_r[11:0], i_sdata};
		sh_nxt     = sh_in;
		sa_nxt     = sa_r;
		addr_nxt   = addr_r;
		bcnt_nxt   = bcnt_r;
		rdx_nxt    = rdx_r;
		drv_nxt    = drv_r;
		drv_oe_nxt = drv_oe_r;
		rsh_nxt    = {rsh_r[6:0], 1'b0};
		cmd        = sh_in[8:1];
		wr_fire    = 1'b0;
		rd_fire    = 1'b0;
		load       = 1'b0;
		xfer_nxt   = {K_WRITE, sh_in[12:9], {3'h0, cmd[4:0]}, {1'b0, cmd[6:0]}};
		rdreq_nxt  = {sa_r, addr_r + 8'h01};
		case (st_r)
			S_CMD: if (cnt_r == CMD_LAST) begin
				cnt_nxt = 4'h0;
				sh_nxt  = '0;
				sa_nxt  = sh_in[12:9];
				st_nxt  = S_IDLE;
				addr_nxt = {3'h0, cmd[4:0]};
				bcnt_nxt = 4'h0;
				rdreq_nxt = {sh_in[12:9], 3'h0, cmd[4:0]};
				if (^sh_in) begin
					if (cmd[7]) begin
						xfer_nxt.addr = {3'h0, A_OUT_EN};
						wr_fire = 1'b1;
					end else if (cmd[7:5] == CMD_WR) begin
						st_nxt = S_WDATA;
					end else if (cmd[7:5] == CMD_RD) begin
						rd_fire = 1'b1;
						st_nxt  = S_RPARK;
					end else if (cmd[7:4] == CMD_EXT_WR || cmd[7:4] == CMD_EXT_RD) begin
						bcnt_nxt = cmd[3:0];
						rdx_nxt  = cmd[5];
						st_nxt   = S_ADDR;
					end else if (cmd[7:3] == CMD_LONG_WR) begin
						xfer_nxt.kind = K_WLONG;
						wr_fire = 1'b1;
					end else if (cmd[7:3] == CMD_LONG_RD) begin
						xfer_nxt.kind = K_RLONG;
						wr_fire = 1'b1;
					end
				end
			end
			S_ADDR: if (cnt_r == BYTE_LAST) begin
				cnt_nxt  = 4'h0;
				sh_nxt   = '0;
				addr_nxt = cmd;
				rdreq_nxt = {sa_r, cmd};
				rd_fire  = (^sh_in) && rdx_r;
				st_nxt   = !(^sh_in) ? S_IDLE : rdx_r ? S_RPARK : S_WDATA;
			end
			S_WDATA: if (cnt_r == BYTE_LAST) begin
				cnt_nxt  = 4'h0;
				sh_nxt   = '0;
				xfer_nxt = {K_WRITE, sa_r, addr_r, cmd};
				wr_fire  = ^sh_in;
				addr_nxt = addr_r + 8'h01;
				bcnt_nxt = bcnt_r - 4'h1;
				st_nxt   = (^sh_in && bcnt_r != 4'h0) ? S_WDATA : S_IDLE;
			end
			S_RPARK: load = 1'b1;
			S_RDATA: begin
				if (cnt_r != BYTE_LAST) begin
					drv_nxt = rsh_r[7];
				end else if (bcnt_r != 4'h0) begin
					load = 1'b1;
				end else begin
					drv_nxt = 1'b0;
					st_nxt  = S_REND;
				end
			end
			S_REND: begin
				drv_nxt    = 1'b0;
				drv_oe_nxt = 1'b0;
				st_nxt     = S_IDLE;
			end
			default: cnt_nxt = cnt_r;
		endcase
		if (load) begin
			drv_nxt    = rdata_r.data[7];
			rsh_nxt    = {rdata_r.data[6:0], ~^rdata_r.data};
			drv_oe_nxt = rdata_r.ok;
			cnt_nxt    = 4'h0;
			st_nxt     = S_RDATA;
			addr_nxt   = addr_r + 8'h01;
			bcnt_nxt   = (st_r == S_RDATA) ? bcnt_r - 4'h1 : bcnt_r;
			rd_fire    = (st_r == S_RDATA) ? (bcnt_r != 4'h1) : (bcnt_r != 4'h0);
		end
	end

	always_ff @(negedge i_sclk or posedge frame_clr_r) begin
		if (frame_clr_r) begin
			st_r     <= S_CMD;
			cnt_r    <= 4'h0;
			sh_r     <= '0;
			sa_r     <= 4'h0;
			addr_r   <= 8'h00;
			bcnt_r   <= 4'h0;
			rdx_r    <= 1'b0;
			drv_r    <= 1'b0;
			drv_oe_r <= 1'b0;
			rsh_r    <= 8'h00;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			sh_r     <= sh_nxt;
			sa_r     <= sa_nxt;
			addr_r   <= addr_nxt;
			bcnt_r   <= bcnt_nxt;
			rdx_r    <= rdx_nxt;
			drv_r    <= drv_nxt;
			drv_oe_r <= drv_oe_nxt;
			rsh_r    <= rsh_nxt;
		end
	end

	// Requests held stable while their toggle crosses to i_mclk
	always_ff @(negedge i_sclk or posedge link_rst_r) begin
		if (link_rst_r) begin
			wr_tgl_r <= 1'b0;
			rd_tgl_r <= 1'b0;
			xfer_r   <= '0;
			rdreq_r  <= '0;
			rdm_s1   <= 1'b0;
			rdm_s2   <= 1'b0;
		end else begin
			rdm_s1 <= rdm_r;
			rdm_s2 <= rdm_s1;
			if (wr_fire) begin
				wr_tgl_r <= ~wr_tgl_r;
				xfer_r   <= xfer_nxt;
			end
			if (rd_fire) begin
				rd_tgl_r <= ~rd_tgl_r;
				rdreq_r  <= rdreq_nxt;
			end
		end
	end

	// ==========================================================
	// Data pin launch: rising edge normally, falling edge when selected
	always_ff @(posedge i_sclk or posedge frame_clr_r) begin
		if (frame_clr_r) begin
			std_r    <= 1'b0;
			std_oe_r <= 1'b0;
		end else begin
			std_r    <= drv_r;
			std_oe_r <= drv_oe_r;
		end
	end

	assign o_sdata    = rdm_s2 ? drv_r : std_r;
	assign o_sdata_oe = rdm_s2 ? drv_oe_r : (std_oe_r && drv_oe_r);

endmodule // rfs_slave_regs

// ---- bench/rfs_slave_regs_monitor.sv ----
// Purpose: Port checks of the serial slave register bank
// Assumes: Link clock half period at least four i_mclk cycles
// Notes:   Bound to rfs_slave_regs from the testbench
module rfs_slave_regs_monitor
	import rfs_pkg::*;
(
	input wire logic           i_mclk,
	input wire logic           i_reset_n,
	input wire logic           i_sclk,
	input wire logic           o_sdata,
	input wire logic           o_sdata_oe,
	input wire logic [2:0]     o_output_enable,
	input wire logic [7:0]     o_booster,
	input wire rfs_dac_t [2:0] o_dac,
	input wire logic [1:0]     o_power_state
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	// ==========================================================
	// Sequences and properties
	sequence s_release;
		$rose(i_reset_n);
	endsequence
	sequence s_drive;
		$rose(o_sdata_oe);
	endsequence
	property p_rst_out;
		s_release |-> o_output_enable == RST_OUT_EN && o_booster == RST_BOOST
			&& o_dac == '0 && o_power_state == RST_PWR_TRIG[7:6];
	endproperty
	property p_rst_oe;
		s_release |-> !o_sdata_oe;
	endproperty
	property p_boost;
		(o_booster & ~BOOST_MASK) == 8'h00;
	endproperty
	property p_oe_hold;
		s_drive |=> o_sdata_oe [*7];
	endproperty
	property p_bit_edge;
		o_sdata_oe && $changed(o_sdata) |-> $changed(i_sclk);
	endproperty
	property p_release;
		$fell(o_sdata_oe) |-> !i_sclk;
	endproperty
	property p_quiet_en;
		$changed(o_output_enable) |-> !o_sdata_oe;
	endproperty
	property p_quiet_dac;
		$changed(o_dac) || $changed(o_power_state) |-> !o_sdata_oe;
	endproperty

	// ==========================================================
	// Assertions
	a_rst_out: assert property (p_rst_out)
		else $error("Outputs not at reset values");
	a_rst_oe: assert property (p_rst_oe)
		else $error("Data pin driven after reset");
	a_boost: assert property (p_boost)
		else $error("Booster spare bit set");
	a_oe_hold: assert property (p_oe_hold)
		else $error("Read drive too short");
	a_bit_edge: assert property (p_bit_edge)
		else $error("Read bit moved off a link edge");
	a_release: assert property (p_release)
		else $error("Data pin released with link clock high");
	a_quiet_en: assert property (p_quiet_en)
		else $error("Enables changed during a read");
	a_quiet_dac: assert property (p_quiet_dac)
		else $error("Active copies changed during a read");
	c_drive: cover property (s_drive);
endmodule // rfs_slave_regs_monitor

// ---- bench/rfs_master_model.sv ----
// Purpose: Link master model driving frames into the register bank
// Assumes: Link clock 80 ns, stopped low between frames
// Notes:   An undriven data line shows the inverse of its last level
module rfs_master_model (
	output logic     o_sclk,
	output logic     o_line,
	input wire logic i_dev_sdata,
	input wire logic i_dev_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic m_oe;
	logic m_d;
	logic last_r;
	logic drove;

	// ==========================================================
	// Line level and drive capture
	assign o_line = i_dev_oe ? i_dev_sdata : (m_oe ? m_d : ~last_r);
	always @(o_sclk) begin
		if (i_dev_oe || m_oe) last_r <= o_line;
	end
	always @(posedge i_dev_oe) drove = 1'b1;
	initial begin
		o_sclk = 1'b0;
		m_oe = 1'b0;
		m_d = 1'b0;
		last_r = 1'b1;
		drove = 1'b0;
	end

	// ==========================================================
	// Frame tasks
	task automatic sbit(input logic b);
		o_sclk = 1'b1;
		m_oe = 1'b1;
		m_d = b;
		#40;
		o_sclk = 1'b0;
		#40;
	endtask
	task automatic sbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) sbit(b[i]);
		sbit(~^b);
	endtask
	task automatic frame(input logic [3:0] sa, input logic [7:0] cmd, input logic [23:0] wb,
		input int nw, input logic re, input logic rdm, output logic [7:0] rd, output logic dv);
		logic [12:0] c;
		logic [8:0]  r9;
		c = {sa, cmd, ~^{sa, cmd}};
		r9 = 9'h000;
		drove = 1'b0;
		#3;
		m_oe = 1'b1;
		m_d = 1'b0;
		#20;
		m_d = 1'b1;
		#20;
		m_d = 1'b0;
		#70;
		for (int i = 12; i >= 0; i--) sbit(c[i]);
		for (int i = 0; i < nw; i++) sbyte(wb[23 - 8 * i -: 8]);
		sbit(1'b0);
		m_oe = 1'b0;
		if (re) begin
			for (int i = 8; i >= 0; i--) begin
				if (rdm) r9[i] = o_line;
				o_sclk = 1'b1;
				#40;
				if (!rdm) r9[i] = o_line;
				o_sclk = 1'b0;
				#40;
			end
			o_sclk = 1'b1;
			#40;
			o_sclk = 1'b0;
			#40;
		end
		rd = r9[8:1];
		dv = drove;
	endtask
endmodule // rfs_master_model

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench of the serial slave register bank
// Assumes: Master model drives the link at an 80 ns period
// Notes:   Each scenario task checks its own results
module testbench
	import rfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] PID_HI = 7'h2C;  // Arbitrary value
	localparam logic [9:0] M_ID   = 10'h1D3; // Arbitrary value
	localparam logic [7:0] SIDV   = {2'b00, M_ID[9:8], RST_SID};
	localparam logic [4:0] TA [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h1A, 5'h1B,
		5'h1C, 5'h1E, 5'h1F};
	localparam logic [7:0] TE [10] = '{8'h00, {2'b00, RST_RESP_SEL}, RST_BOOST & BOOST_MASK,
		RST_DAC_FIELD, RST_BYTE, {6'h00, RST_STATUS}, RST_BYTE, RST_PWR_TRIG, M_ID[7:0], SIDV};
	logic           mclk;
	logic           rst_n;
	logic           strap;
	logic           sclk;
	logic           line;
	logic           dsd;
	logic           doe;
	logic [2:0]     oen;
	logic [7:0]     boost;
	rfs_dac_t [2:0] dac;
	logic [1:0]     pwr;
	logic           rdm;
	logic [7:0]     v;
	logic           drv;
	int             err_count;
	int             compares;

	always #5 mclk = ~mclk;

	rfs_slave_regs #(.PRODUCT_ID_HI(PID_HI), .MANUF_ID(M_ID)) dut (.i_mclk(mclk),
		.i_reset_n(rst_n), .i_sclk(sclk), .i_sdata(line), .i_otp_pid_lsb(strap),
		.o_sdata(dsd), .o_sdata_oe(doe), .o_output_enable(oen), .o_booster(boost),
		.o_dac(dac), .o_power_state(pwr));
	rfs_master_model mst (.o_sclk(sclk), .o_line(line), .i_dev_sdata(dsd), .i_dev_oe(doe));

	// ==========================================================
	// Shared tasks
	task automatic end_sim();
		$display("Mismatches %0d of %0d compares", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic [3:0] sa, input logic [7:0] cmd, input logic [23:0] wb,
		input int nw, input logic re);
		mst.frame(sa, cmd, wb, nw, re, rdm, v, drv);
		repeat (8) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d);
		go(sa, {3'b010, a}, {d, 16'h0000}, 1, 1'b0);
	endtask
	task automatic rc(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] e);
		go(sa, {3'b011, a}, 24'h00_0000, 0, 1'b1);
		chk8(v, e);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_vals();
		for (int i = 0; i < 10; i++) rc(4'h7, TA[i], TE[i]);
		rc(4'h7, 5'h18, SIDV);
		rc(4'h7, 5'h19, SIDV);
		strap = 1'b0;
		rc(4'h7, 5'h1D, {PID_HI, 1'b0});
		strap = 1'b1;
		rc(4'h7, 5'h1D, {PID_HI, 1'b1});
	endtask
	task automatic t_regs();
		go(4'h7, {1'b1, 7'h05}, 24'h00_0000, 0, 1'b0);
		chk8({5'h00, oen}, 8'h05);
		rc(4'h7, 5'h00, 8'h05);
		wr(4'h7, 5'h02, 8'hFF);
		chk8(boost, 8'hDF);
		rc(4'h7, 5'h02, 8'hDF);
		wr(4'h7, 5'h0A, 8'h5A);
		wr(4'h7, 5'h17, 8'hA5);
		rc(4'h7, 5'h0A, 8'h5A);
		rc(4'h7, 5'h17, 8'hA5);
		wr(4'h7, 5'h1D, 8'h00);
		wr(4'h7, 5'h1E, 8'h00);
		rc(4'h7, 5'h1D, {PID_HI, 1'b1});
		rc(4'h7, 5'h1E, M_ID[7:0]);
		wr(4'h7, 5'h1C, 8'hF8);
		chk8({6'h00, pwr}, 8'h03);
		rc(4'h7, 5'h1C, 8'hF8);
		wr(4'h7, 5'h1C, RST_PWR_TRIG);
	endtask
	task automatic t_ext();
		go(4'h7, {CMD_EXT_WR, 4'h0}, {8'h09, 8'h01, 8'h00}, 2, 1'b0);
		rdm = 1'b1;
		go(4'h7, {CMD_EXT_RD, 4'h0}, {8'h1E, 16'h0000}, 1, 1'b1);
		chk8(v, M_ID[7:0]);
		rc(4'h7, 5'h09, 8'h01);
		go(4'h7, {CMD_EXT_WR, 4'h1}, {8'h0B, 8'h11, 8'h22}, 3, 1'b0);
		wr(4'h7, 5'h09, 8'h00);
		rdm = 1'b0;
		rc(4'h7, 5'h0B, 8'h11);
		rc(4'h7, 5'h0C, 8'h22);
	endtask
	task automatic t_long();
		go(4'h7, {CMD_LONG_WR, 3'h0}, {8'h00, 8'h02, 8'h00}, 3, 1'b0);
		rc(4'h7, 5'h02, 8'hDF);
		rc(4'h7, 5'h1A, 8'h01);
		go(4'h7, {CMD_LONG_RD, 3'h0}, {8'h00, 8'h1E, 8'h00}, 2, 1'b1);
		chk8({7'h00, drv}, 8'h00);
		rc(4'h7, 5'h1A, 8'h03);
		wr(4'h7, 5'h1A, 8'h01);
		rc(4'h7, 5'h1A, 8'h02);
		wr(4'h7, 5'h1A, 8'h02);
		rc(4'h7, 5'h1A, 8'h00);
	endtask
	task automatic t_access();
		wr(4'h7, 5'h03, 8'h0F);
		wr(4'h7, 5'h06, 8'h44);
		chk8(dac[0].timer, 8'h0F);
		chk8(dac[0].target, 8'h44);
		wr(4'h0, 5'h06, 8'h99);
		rc(4'h7, 5'h06, 8'h44);
		wr(4'h7, 5'h18, 8'h28);
		rc(4'h8, 5'h18, {2'b00, M_ID[9:8], 4'h8});
		wr(4'h7, 5'h01, 8'h3D);
		wr(4'h7, 5'h06, 8'h55);
		chk8(dac[0].target, 8'h44);
		wr(4'h8, 5'h06, 8'h55);
		rc(4'h8, 5'h06, 8'h55);
		wr(4'h7, 5'h1C, 8'h28);
		wr(4'h8, 5'h06, 8'h66);
		rc(4'h8, 5'h06, 8'h55);
		chk8(dac[0].target, 8'h55);
		wr(4'h7, 5'h1C, 8'h2A);
		chk8(dac[0].target, 8'h66);
		rc(4'h7, 5'h1C, 8'h28);
		wr(4'h7, 5'h1B, 8'h05);
		wr(4'h5, 5'h02, 8'h11);
		chk8(boost, 8'h11);
		rc(4'h7, 5'h1B, 8'h05);
	endtask
	task automatic t_outs();
		wr(4'h7, 5'h1C, RST_PWR_TRIG);
		wr(4'h0, 5'h19, 8'h09);
		rc(4'h9, 5'h19, {2'b00, M_ID[9:8], 4'h9});
		wr(4'h7, 5'h01, 8'h21);
		wr(4'h7, 5'h04, 8'h12);
		wr(4'h7, 5'h07, 8'h77);
		chk8(dac[1].timer, 8'h12);
		chk8(dac[1].target, 8'h77);
		wr(4'h7, 5'h08, 8'h88);
		chk8(dac[2].target, 8'h00);
		go(4'h7, {3'b011, 5'h08}, 24'h00_0000, 0, 1'b1);
		chk8({7'h00, drv}, 8'h00);
		wr(4'h9, 5'h05, 8'h3C);
		wr(4'h9, 5'h08, 8'h88);
		chk8(dac[2].timer, 8'h3C);
		chk8(dac[2].target, 8'h88);
		rc(4'h9, 5'h08, 8'h88);
	endtask
	task automatic t_reset2();
		rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		chk8({5'h00, oen}, 8'h00);
		rc(4'h7, 5'h18, SIDV);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		strap = 1'b1;
		rdm = 1'b0;
		err_count = 0;
		compares = 0;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		t_reset_vals();
		t_regs();
		t_ext();
		t_long();
		t_access();
		t_outs();
		t_reset2();
		end_sim();
	end
	initial begin
		#500_000;
		err_count++;
		end_sim();
	end
endmodule // testbench

bind rfs_slave_regs rfs_slave_regs_monitor u_mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_sclk(i_sclk), .o_sdata(o_sdata), .o_sdata_oe(o_sdata_oe),
	.o_output_enable(o_output_enable), .o_booster(o_booster), .o_dac(o_dac),
	.o_power_state(o_power_state));
